// File: shared/pkp_pkg.sv
// constants and carriers of the page-key packet parser
`default_nettype none
package pkp_pkg;

  // ************************************************************
  // register map, byte offsets on the bus
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PAGE = 8'h08;
  localparam logic [7:0] ADDR_SERVICE = 8'h0c;
  localparam logic [7:0] ADDR_CREDIT = 8'h10;
  localparam logic [7:0] ADDR_TAIL = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_LENGTH = 8'h1c;
  localparam logic [7:0] ADDR_CHECK = 8'h20;
  localparam logic [7:0] ADDR_SKEY_LO = 8'h24;
  localparam logic [7:0] ADDR_SKEY_HI = 8'h28;
  localparam logic [7:0] ADDR_PKEY_LO = 8'h2c;
  localparam logic [7:0] ADDR_PKEY_HI = 8'h30;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;

  // ************************************************************
  // packet layout, positions in transmission order from bit 0
  // ************************************************************
  localparam logic [3:0] DC_PAGE_KEY = 4'h2;
  localparam int GRP_W = 18;
  localparam int STREAM_W = 234;
  localparam logic [3:0] GRP_LAST = 4'hc;
  localparam logic [3:0] GRP_ENC_FIRST = 4'h1;
  localparam logic [3:0] GRP_ENC_LAST = 4'h8;
  localparam int POS_PTYPE = 0;
  localparam int POS_RSVD = 8;
  localparam int POS_FMT = 14;
  localparam int POS_MODE = 18;
  localparam int POS_SKEY = 26;
  localparam int POS_SID = 82;
  localparam int POS_PKEY = 90;
  localparam int POS_FRAC = 146;
  localparam int POS_WHOLE = 154;
  localparam int POS_CONT = 162;
  localparam int POS_RPT = 169;
  localparam int POS_FLAGS = 170;
  localparam int POS_METHOD = 197;
  localparam int POS_LABEL = 202;
  localparam int POS_CHK_HI = 218;
  localparam int POS_CHK_LO = 226;

  // ************************************************************
  // field codes
  // ************************************************************
  localparam logic [7:0] PTYPE_REFMT = 8'h84;
  localparam logic [7:0] PTYPE_TEA = 8'h85;
  localparam logic [1:0] MODE_NONTIER = 2'h0;
  localparam logic [1:0] MODE_TIERED = 2'h1;
  localparam logic [1:0] MODE_CREDIT = 2'h2;
  localparam logic [1:0] MODE_NONE = 2'h3;
  localparam logic [1:0] TIER_NONE = 2'h3;
  localparam logic [6:0] CONT_MAX = 7'h7e;
  localparam logic [4:0] MRAW_OWF_A = 5'h00;
  localparam logic [4:0] MRAW_BLOCK = 5'h01;
  localparam logic [4:0] MRAW_OWF_B = 5'h02;
  localparam logic [4:0] MRAW_NONTTX = 5'h03;
  localparam logic [4:0] MRAW_UNSPEC = 5'h1f;
  localparam logic [2:0] MTH_OWF_A = 3'h0;
  localparam logic [2:0] MTH_BLOCK = 3'h1;
  localparam logic [2:0] MTH_OWF_B = 3'h2;
  localparam logic [2:0] MTH_NONTTX = 3'h3;
  localparam logic [2:0] MTH_UNSPEC = 3'h4;
  localparam logic [2:0] MTH_UNKNOWN = 3'h5;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [17:0] data;
    logic [17:0] key;
  } pkp_grp_t;

  typedef struct packed {
    logic [7:0] page_type;
    logic [3:0] fmt;
    logic fmt_ok;
    logic [1:0] mode;
    logic [7:0] sid;
    logic [7:0] svc;
    logic [1:0] tier;
    logic [7:0] frac;
    logic [7:0] whole;
    logic [6:0] cont;
    logic rpt;
    logic [25:0] flags;
    logic [9:0] dlen;
    logic [4:0] mraw;
    logic [2:0] method;
    logic [7:0] label;
    logic [15:0] chk_rx;
    logic [55:0] skey;
    logic [55:0] pkey;
  } pkp_fields_t;

endpackage
`default_nettype wire

// File: design/pkp_chk.sv
// page check-word shift register, one page byte per clock
`timescale 1ns/10ps
`default_nettype none
module pkp_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clr,
  // page bytes
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // check word, bit k-1 holds stage k
  output logic [15:0] word_q
);

  logic [15:0] word_d;

  // eight shifts, bit b8 first
  function automatic logic [15:0] shift_byte(input logic [15:0] r, input logic [7:0] b);
    logic [15:0] s;
    s = r;
    for (int i = 7; i >= 0; i--) begin
      s = {s[14:0], b[i] ^ s[6] ^ s[8] ^ s[11] ^ s[15]};
    end
    return s;
  endfunction

  always_comb begin
    word_d = word_q;
    if (clr) begin
      word_d = '0;
    end else if (byte_valid) begin
      word_d = shift_byte(word_q, byte_in);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  AST_CHK_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !clr && !byte_valid |=> $stable(word_q))
    else $error("check word moved without a byte");

  AST_CHK_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    clr |=> word_q == 16'h0000)
    else $error("check word not cleared");

endmodule
`default_nettype wire

// File: design/pkp_parser.sv
// page-key packet field extractor with its bus slave
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pkp_parser (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata_q,
  output logic hreadyout_q,
  output logic hresp_q,
  // corrected packet, same clock
  input wire logic dc_valid,
  input wire logic [3:0] dc_data,
  input wire logic grp_valid,
  input wire pkp_pkg::pkp_grp_t grp,
  // page bytes for the check word, same clock
  input wire logic pg_valid,
  input wire logic [7:0] pg_byte,
  // event
  output logic pkt_done_q
);

  typedef enum logic {PK_IDLE, PK_COLLECT} pkp_state_t;

  // ************************************************************
  // bus slave
  // ************************************************************
  logic sel_ok;
  logic wr_q, wr_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] rdata_d, rd_word;
  logic en_q, en_d;
  logic clr_q, clr_d;
  logic [15:0] chk_calc;
  pkp_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [pkp_pkg::STREAM_W-1:0] strm_q, strm_d;
  pkp_pkg::pkp_fields_t fld_q, fld_d;
  logic vld_q, vld_d;
  logic brk_q, brk_d;
  logic done_d;
  logic enc;
  logic [17:0] grp_word;

  assign sel_ok = hsel && hready && htrans[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      pkp_pkg::ADDR_CTRL: rd_word = {31'h0, en_q};
      pkp_pkg::ADDR_STATUS: rd_word = {21'h0, fld_q.method, chk_calc == fld_q.chk_rx, brk_q,
        fld_q.tier == pkp_pkg::TIER_NONE, fld_q.mode == pkp_pkg::MODE_NONE, fld_q.fmt_ok,
        fld_q.page_type == pkp_pkg::PTYPE_TEA, fld_q.page_type == pkp_pkg::PTYPE_REFMT, vld_q};
      pkp_pkg::ADDR_PAGE: rd_word = {20'h0, fld_q.fmt, fld_q.page_type};
      pkp_pkg::ADDR_SERVICE: rd_word = {12'h0, fld_q.sid, fld_q.mode, fld_q.tier, fld_q.svc};
      pkp_pkg::ADDR_CREDIT: rd_word = {16'h0, fld_q.whole, fld_q.frac};
      pkp_pkg::ADDR_TAIL: rd_word = {8'h0, fld_q.label, fld_q.method, fld_q.mraw, fld_q.rpt,
        fld_q.cont};
      pkp_pkg::ADDR_FLAGS: rd_word = {6'h0, fld_q.flags};
      pkp_pkg::ADDR_LENGTH: rd_word = {22'h0, fld_q.dlen};
      pkp_pkg::ADDR_CHECK: rd_word = {chk_calc, fld_q.chk_rx};
      pkp_pkg::ADDR_SKEY_LO: rd_word = fld_q.skey[31:0];
      pkp_pkg::ADDR_SKEY_HI: rd_word = {8'h0, fld_q.skey[55:32]};
      pkp_pkg::ADDR_PKEY_LO: rd_word = fld_q.pkey[31:0];
      pkp_pkg::ADDR_PKEY_HI: rd_word = {8'h0, fld_q.pkey[55:32]};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    wr_d = sel_ok && hwrite;
    waddr_d = sel_ok ? haddr[7:0] : waddr_q;
    rdata_d = (sel_ok && !hwrite) ? rd_word : hrdata_q;
    en_d = en_q;
    clr_d = 1'b0;
    if (wr_q && waddr_q == pkp_pkg::ADDR_CTRL) begin
      en_d = hwdata[pkp_pkg::CTRL_EN_BIT];
      clr_d = hwdata[pkp_pkg::CTRL_CLR_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      en_q <= pkp_pkg::CTRL_EN_RST;
      clr_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      waddr_q <= waddr_d;
      hrdata_q <= rdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      en_q <= en_d;
      clr_q <= clr_d;
    end
  end

  // ************************************************************
  // field decode
  // ************************************************************
  function automatic logic [2:0] method_code(input logic [4:0] m);
    unique case (m)
      pkp_pkg::MRAW_OWF_A: method_code = pkp_pkg::MTH_OWF_A;
      pkp_pkg::MRAW_BLOCK: method_code = pkp_pkg::MTH_BLOCK;
      pkp_pkg::MRAW_OWF_B: method_code = pkp_pkg::MTH_OWF_B;
      pkp_pkg::MRAW_NONTTX: method_code = pkp_pkg::MTH_NONTTX;
      pkp_pkg::MRAW_UNSPEC: method_code = pkp_pkg::MTH_UNSPEC;
      default: method_code = pkp_pkg::MTH_UNKNOWN;
    endcase
  endfunction

  function automatic logic [6:0] cont_next(input logic [6:0] c);
    return (c == pkp_pkg::CONT_MAX) ? 7'h00 : c + 7'h01;
  endfunction

  function automatic pkp_pkg::pkp_fields_t decode(input logic [pkp_pkg::STREAM_W-1:0] s);
    pkp_pkg::pkp_fields_t f;
    f = '0;
    f.page_type = s[pkp_pkg::POS_PTYPE +: 8];
    f.fmt = s[pkp_pkg::POS_FMT +: 4];
    f.fmt_ok = s[pkp_pkg::POS_RSVD +: 6] == 6'h00;
    f.mode = s[pkp_pkg::POS_MODE +: 2];
    f.skey = s[pkp_pkg::POS_SKEY +: 56];
    f.sid = s[pkp_pkg::POS_SID +: 8];
    f.pkey = s[pkp_pkg::POS_PKEY +: 56];
    if (f.mode == pkp_pkg::MODE_TIERED) begin
      f.svc = {2'h0, f.sid[7:2]};
      f.tier = f.sid[1:0];
    end else begin
      f.svc = f.sid;
      f.tier = 2'h0;
    end
    f.frac = s[pkp_pkg::POS_FRAC +: 8];
    f.whole = s[pkp_pkg::POS_WHOLE +: 8];
    f.cont = s[pkp_pkg::POS_CONT +: 7];
    f.rpt = s[pkp_pkg::POS_RPT];
    if (f.page_type == pkp_pkg::PTYPE_REFMT) begin
      f.dlen = s[pkp_pkg::POS_FLAGS +: 10];
    end else begin
      f.flags = s[pkp_pkg::POS_FLAGS +: 26];
    end
    f.mraw = s[pkp_pkg::POS_METHOD +: 5];
    f.method = method_code(f.mraw);
    f.label = s[pkp_pkg::POS_LABEL +: 8];
    f.chk_rx = {s[pkp_pkg::POS_CHK_HI +: 8], s[pkp_pkg::POS_CHK_LO +: 8]};
    return f;
  endfunction

  // ************************************************************
  // packet collection
  // ************************************************************
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    strm_d = strm_q;
    fld_d = fld_q;
    vld_d = vld_q;
    brk_d = brk_q;
    done_d = 1'b0;
    enc = cnt_q >= pkp_pkg::GRP_ENC_FIRST && cnt_q <= pkp_pkg::GRP_ENC_LAST;
    grp_word = grp.data ^ (enc ? grp.key : 18'h00000);
    if (dc_valid && en_q) begin
      st_d = (dc_data == pkp_pkg::DC_PAGE_KEY) ? PK_COLLECT : PK_IDLE;
      cnt_d = 4'h0;
    end else if (st_q == PK_COLLECT && grp_valid) begin
      strm_d = {grp_word, strm_q[pkp_pkg::STREAM_W-1:pkp_pkg::GRP_W]};
      if (cnt_q == pkp_pkg::GRP_LAST) begin
        st_d = PK_IDLE;
        done_d = 1'b1;
        fld_d = decode(strm_d);
        vld_d = 1'b1;
        brk_d = vld_q && fld_d.svc == fld_q.svc
          && fld_d.cont != cont_next(fld_q.cont);
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= PK_IDLE;
      cnt_q <= 4'h0;
      strm_q <= '0;
      fld_q <= '0;
      vld_q <= 1'b0;
      brk_q <= 1'b0;
      pkt_done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      strm_q <= strm_d;
      fld_q <= fld_d;
      vld_q <= vld_d;
      brk_q <= brk_d;
      pkt_done_q <= done_d;
    end
  end

  pkp_chk u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(clr_q),
    .byte_valid(pg_valid),
    .byte_in(pg_byte),
    .word_q(chk_calc)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_last_grp;
    st_q == PK_COLLECT && grp_valid && !(dc_valid && en_q) && cnt_q == pkp_pkg::GRP_LAST;
  endsequence

  sequence seq_bad_dc;
    dc_valid && en_q && dc_data != pkp_pkg::DC_PAGE_KEY;
  endsequence

  AST_DC_FILTER: assert property (seq_bad_dc |=> st_q == PK_IDLE ##1 !pkt_done_q)
    else $error("packet taken with wrong designation code");

  AST_GROUP_END: assert property (seq_last_grp |=> pkt_done_q && st_q == PK_IDLE)
    else $error("no completion after thirteenth group");

  AST_DONE_CAUSE: assert property (pkt_done_q |-> $past(cnt_q) == pkp_pkg::GRP_LAST)
    else $error("completion without thirteen groups");

  AST_PAGE_TYPE: assert property (pkt_done_q |-> fld_q.page_type == strm_q[7:0])
    else $error("page type not from first group");

  AST_DECRYPT: assert property (st_q == PK_COLLECT && grp_valid && !dc_valid
    && cnt_q == 4'h1 |=> strm_q[233:216] == $past(grp.data ^ grp.key))
    else $error("encrypted group not decrypted");

  AST_CLEAR_TAIL: assert property (st_q == PK_COLLECT && grp_valid && !dc_valid
    && cnt_q == 4'h9 |=> strm_q[233:216] == $past(grp.data))
    else $error("clear group altered");

  AST_MODE_TIERED: assert property (pkt_done_q && fld_q.mode == pkp_pkg::MODE_TIERED
    |-> fld_q.svc == {2'h0, fld_q.sid[7:2]} && fld_q.tier == fld_q.sid[1:0])
    else $error("tiered service split wrong");

  AST_MODE_FLAT: assert property (pkt_done_q && fld_q.mode != pkp_pkg::MODE_TIERED
    |-> fld_q.svc == fld_q.sid && fld_q.tier == 2'h0)
    else $error("flat service number wrong");

  AST_CREDIT: assert property (pkt_done_q |-> fld_q.whole == strm_q[161:154]
    && fld_q.frac == strm_q[153:146])
    else $error("credit halves swapped");

  AST_METHOD: assert property (pkt_done_q && strm_q[201:197] == 5'h01
    |-> fld_q.method == pkp_pkg::MTH_BLOCK)
    else $error("method code misread");

  AST_CONT_BREAK: assert property (pkt_done_q && $past(vld_q)
    && fld_q.svc == $past(fld_q.svc)
    && fld_q.cont == cont_next($past(fld_q.cont)) |-> !brk_q)
    else $error("false continuity break");

  AST_LENGTH: assert property (pkt_done_q && fld_q.page_type == pkp_pkg::PTYPE_REFMT
    |-> fld_q.dlen == strm_q[179:170] && fld_q.flags == 26'h0)
    else $error("data length misplaced");

endmodule
`default_nettype wire

// File: bench/pkp_tx_model.sv
// broadcast side model that sends page-key packets to the parser
`timescale 1ns/10ps
`default_nettype none
module pkp_tx_model (
  // clock
  input wire logic hclk,
  // corrected packet toward the parser
  output logic dc_valid,
  output logic [3:0] dc_data,
  output logic grp_valid,
  output pkp_pkg::pkp_grp_t grp
);
  // ************************************************
  // packet sender, gap idle cycles between groups
  // ************************************************
  initial begin
    dc_valid = 1'b0;
    dc_data = 4'h5;
    grp_valid = 1'b0;
    grp = '0;
  end

  task automatic send(input logic [233:0] s, input logic [3:0] dc, input int gap);
    logic [17:0] ks;
    @(posedge hclk);
    dc_valid <= 1'b1;
    dc_data <= dc;
    for (int g = 0; g < 13; g++) begin
      ks = 18'h2b3c5 ^ {g[5:0], g[5:0], g[5:0]};
      @(posedge hclk);
      dc_valid <= 1'b0;
      dc_data <= ~dc;
      repeat (gap) begin
        grp_valid <= 1'b0;
        grp <= ~grp;
        @(posedge hclk);
      end
      grp_valid <= 1'b1;
      grp.key <= ks;
      // keystream only on the secret bits, head and tail go clear
      grp.data <= s[g * 18 +: 18] ^ ((g >= 1 && g <= 8) ? ks : 18'h0);
    end
    @(posedge hclk);
    grp_valid <= 1'b0;
    grp <= ~grp;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_page_key_packet_parser.sv
// self-checking bench of the page-key packet parser
`timescale 1ns/10ps
`default_nettype none
module tb_page_key_packet_parser;
  // ************************************************
  // signals, design and sender
  // ************************************************
  localparam logic [55:0] SKEY = 56'h13579bdf02468a;
  localparam logic [55:0] PKEY = 56'hfedcba98765432;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pg_valid = 1'b0;
  logic [7:0] pg_byte = 8'h0;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic pkt_done_q;
  logic dc_valid;
  logic grp_valid;
  logic [3:0] dc_data;
  pkp_pkg::pkp_grp_t grp;
  logic [15:0] crc = 16'h0;
  int failures = 0;
  int cmp_count = 0;
  int done_n = 0;
  int d0;

  always #25 hclk = ~hclk;

  always @(posedge hclk) if (pkt_done_q === 1'b1) done_n <= done_n + 1;

  pkp_parser DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout_q),
    .hrdata_q(hrdata_q),
    .hreadyout_q(hreadyout_q),
    .hresp_q(hresp_q),
    .dc_valid(dc_valid),
    .dc_data(dc_data),
    .grp_valid(grp_valid),
    .grp(grp),
    .pg_valid(pg_valid),
    .pg_byte(pg_byte),
    .pkt_done_q(pkt_done_q)
  );

  pkp_tx_model TX (
    .hclk(hclk),
    .dc_valid(dc_valid),
    .dc_data(dc_data),
    .grp_valid(grp_valid),
    .grp(grp)
  );

  // ************************************************
  // tasks
  // ************************************************
  task automatic stop_test;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout_q !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout_q !== 1'b1) @(posedge hclk);
    v = hrdata_q;
    cmp({31'h0, hresp_q}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    cmp(v, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
    @(posedge hclk);
  endtask

  // page byte into the design and into the local check-word register
  task automatic feed(input logic [7:0] b);
    logic fb;
    @(posedge hclk);
    pg_valid <= 1'b1;
    pg_byte <= b;
    for (int i = 7; i >= 0; i--) begin
      fb = b[i] ^ crc[6] ^ crc[8] ^ crc[11] ^ crc[15];
      crc = {crc[14:0], fb};
    end
    @(posedge hclk);
    pg_valid <= 1'b0;
    pg_byte <= ~b;
  endtask

  function automatic logic [2:0] mcode(input logic [4:0] r);
    case (r)
      5'h00: return pkp_pkg::MTH_OWF_A;
      5'h01: return pkp_pkg::MTH_BLOCK;
      5'h02: return pkp_pkg::MTH_OWF_B;
      5'h03: return pkp_pkg::MTH_NONTTX;
      5'h1f: return pkp_pkg::MTH_UNSPEC;
      default: return pkp_pkg::MTH_UNKNOWN;
    endcase
  endfunction

  // builds, sends and reads back one packet
  task automatic pkt(input logic [7:0] pt, input logic [1:0] md, input logic [7:0] sid,
                     input logic [6:0] ct, input logic rp, input logic [25:0] fl,
                     input logic [4:0] mr, input logic [15:0] ck, input logic brk,
                     input int gap);
    logic [233:0] s;
    logic [7:0] sv;
    logic [1:0] tr;
    logic rf;
    int n0;
    s = '0;
    s[7:0] = pt;
    s[pkp_pkg::POS_RSVD] = (pt == 8'h85);
    s[17:14] = 4'h1;
    s[pkp_pkg::POS_MODE +: 2] = md;
    s[pkp_pkg::POS_SKEY +: 56] = SKEY;
    s[pkp_pkg::POS_SID +: 8] = sid;
    s[pkp_pkg::POS_PKEY +: 56] = PKEY;
    s[pkp_pkg::POS_FRAC +: 8] = sid ^ 8'h5a;
    s[pkp_pkg::POS_WHOLE +: 8] = ~sid;
    s[pkp_pkg::POS_CONT +: 7] = ct;
    s[pkp_pkg::POS_RPT] = rp;
    s[pkp_pkg::POS_FLAGS +: 26] = fl;
    s[pkp_pkg::POS_METHOD +: 5] = mr;
    s[pkp_pkg::POS_LABEL +: 8] = sid + 8'h1;
    s[pkp_pkg::POS_CHK_HI +: 8] = ck[15:8];
    s[pkp_pkg::POS_CHK_LO +: 8] = ck[7:0];
    rf = (pt == 8'h84);
    sv = (md == 2'h1) ? {2'h0, sid[7:2]} : sid;
    tr = (md == 2'h1) ? sid[1:0] : 2'h0;
    n0 = done_n;
    TX.send(s, 4'h2, gap);
    while (done_n == n0) @(posedge hclk);
    repeat (3) @(posedge hclk);
    cmp(32'(done_n - n0), 32'h1);
    rd(pkp_pkg::ADDR_STATUS, {21'h0, mcode(mr), ck == crc, brk, md == 2'h1 && tr == 2'h3,
       md == 2'h3, pt != 8'h85, pt == 8'h85, rf, 1'b1});
    rd(pkp_pkg::ADDR_PAGE, {20'h0, 4'h1, pt});
    rd(pkp_pkg::ADDR_SERVICE, {12'h0, sid, md, tr, sv});
    rd(pkp_pkg::ADDR_CREDIT, {16'h0, ~sid, sid ^ 8'h5a});
    rd(pkp_pkg::ADDR_TAIL, {8'h0, sid + 8'h1, mcode(mr), mr, rp, ct});
    rd(pkp_pkg::ADDR_FLAGS, rf ? 32'h0 : {6'h0, fl});
    rd(pkp_pkg::ADDR_LENGTH, rf ? {22'h0, fl[9:0]} : 32'h0);
    rd(pkp_pkg::ADDR_CHECK, {crc, ck});
    rd(pkp_pkg::ADDR_SKEY_LO, SKEY[31:0]);
    rd(pkp_pkg::ADDR_SKEY_HI, {8'h0, SKEY[55:32]});
    rd(pkp_pkg::ADDR_PKEY_LO, PKEY[31:0]);
    rd(pkp_pkg::ADDR_PKEY_HI, {8'h0, PKEY[55:32]});
  endtask

  // ************************************************
  // test sequence and watchdog
  // ************************************************
  initial begin
    repeat (20) @(posedge hclk);
    cmp({29'h0, hreadyout_q, hresp_q, pkt_done_q}, 32'h4);
    hresetn <= 1'b1;
    rd(pkp_pkg::ADDR_CTRL, 32'h1);
    rd(8'h40, 32'h0);
    feed(8'h41);
    feed(8'h20);
    feed(8'hc3);
    pkt(8'h00, 2'h0, 8'h37, 7'd126, 1'b1, 26'h2000001, 5'h00, crc, 1'b0, 0);
    pkt(8'h00, 2'h0, 8'h37, 7'd0, 1'b0, 26'h0aaaaaa, 5'h01, ~crc, 1'b0, 2);
    pkt(8'h00, 2'h0, 8'h37, 7'd5, 1'b0, 26'h1555555, 5'h02, 16'h0, 1'b1, 0);
    for (int t = 0; t < 4; t++) begin
      pkt(8'h00, 2'h1, {6'h2a, t[1:0]}, 7'(10 + t), 1'b1, 26'hfff, 5'h03, 16'h1234, 1'b0,
          t);
    end
    pkt(8'h84, 2'h3, 8'h99, 7'd3, 1'b0, 26'h3ff, 5'h1f, 16'h0, 1'b0, 1);
    pkt(8'h85, 2'h2, 8'ha0, 7'd9, 1'b1, 26'h3ffffff, 5'h05, 16'hbeef, 1'b0, 0);
    d0 = done_n;
    TX.send({234{1'b1}}, 4'h4, 0);
    repeat (3) @(posedge hclk);
    cmp(32'(done_n - d0), 32'h0);
    rd(pkp_pkg::ADDR_TAIL, {8'h0, 8'ha1, pkp_pkg::MTH_UNKNOWN, 5'h05, 1'b1, 7'd9});
    wr(pkp_pkg::ADDR_CTRL, 32'h0);
    TX.send({234{1'b1}}, 4'h2, 0);
    repeat (3) @(posedge hclk);
    cmp(32'(done_n - d0), 32'h0);
    wr(pkp_pkg::ADDR_CTRL, 32'h3);
    crc = 16'h0;
    rd(pkp_pkg::ADDR_CHECK, {crc, 16'hbeef});
    rd(pkp_pkg::ADDR_CTRL, 32'h1);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
